// file: logic/pvpc_top.sv
// What this block does
// - Nine power-down test bits, read/write, reset zero
// - Selected power-down bits take configured level
// - Level bit: one powers down, zero normal
// - Force signal detect good at 100 Mbps
// - Shorten 10BASE-T preamble by 12 or 22
// - Preamble control set keeps normal preamble
// - Bit enables 10 Mbps transmit power saving
// - Zero enables auto-negotiation power saving
// - Read-only bit shows crossover state
// - Bit runs internal auto-negotiation loopback
// - Auto-disable forces crossover to fixed value
// - Reserved read-only bits read zero
// - Two test select bits are storage
// - Sixteen-bit DSP test word, reset zero
// - Reduce drive current when cable unconnected
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pvpc_regs.svh"

module pvpc_top #(
  parameter int PD_BITS = `PVPC_PD_BITS
) (
  input  wire logic                        clk,
  input  wire logic                        reset,
  input  wire pvpc_pkg::pvpc_bus_t         bus,
  input  wire pvpc_pkg::pvpc_phy_t         phy,
  output var  logic [`PVPC_DATA_W-1:0]     rd_data,
  output var  logic [PD_BITS-1:0]          pd_ctl,
  output var  logic                        signal_detect_ok,
  output var  logic [`PVPC_PRE_W-1:0]      preamble_cut_bits,
  output var  logic                        tx_10m_power_save,
  output var  logic                        autoneg_power_save_en,
  output var  logic                        crossover_state,
  output var  logic                        auto_crossover_en,
  output var  logic                        autoneg_internal_loopback,
  output var  logic [`PVPC_DATA_W-1:0]     dsp_test_word,
  output var  logic                        tx_amplitude_reduce,
  output var  logic                        tx_drive_current_save
);

  import pvpc_pkg::*;

  // Refuse widths the power-down map cannot hold
  if (PD_BITS < 1 || PD_BITS > `PVPC_PD_BITS) begin : g_pd_check
    $error("PD_BITS out of range");
  end

  // The stored image must never hold the live crossover bit
  localparam logic [`PVPC_DATA_W-1:0] CFG_KEEP = `PVPC_CFG_RW_MASK;
  if (CFG_KEEP[`PVPC_CFG_XOVER]) begin : g_cfg_mask_check
    $error("crossover bit must stay read-only");
  end

  // Every power saving control must sit inside the writable mask
  localparam logic [`PVPC_DATA_W-1:0] PSC_KEEP = `PVPC_PSC_RW_MASK;
  if (!PSC_KEEP[`PVPC_PSC_PRE_SHORT] || !PSC_KEEP[`PVPC_PSC_AMPLITUDE] ||
      !PSC_KEEP[`PVPC_PSC_TX_DRIVE]) begin : g_psc_mask_check
    $error("power saving control outside writable mask");
  end

  // Unique decode needs four distinct register indices
  if (`PVPC_ADDR_PD == `PVPC_ADDR_CFG || `PVPC_ADDR_PD == `PVPC_ADDR_DSP ||
      `PVPC_ADDR_PD == `PVPC_ADDR_PSC || `PVPC_ADDR_CFG == `PVPC_ADDR_DSP ||
      `PVPC_ADDR_CFG == `PVPC_ADDR_PSC || `PVPC_ADDR_DSP == `PVPC_ADDR_PSC) begin : g_addr_check
    $error("register indices overlap");
  end

  // A zero cut would hide the shortening altogether
  if (`PVPC_PRE_CUT_LONG == `PVPC_PRE_NONE ||
      `PVPC_PRE_CUT_SHORT == `PVPC_PRE_NONE) begin : g_pre_check
    $error("preamble cut lengths must be nonzero");
  end

  // Stored register images
  logic [PD_BITS-1:0]      pd_reg;
  logic [`PVPC_DATA_W-1:0] cfg_reg;
  logic [`PVPC_DATA_W-1:0] dsp_reg;
  logic [`PVPC_DATA_W-1:0] psc_reg;

  // Read path
  logic [`PVPC_DATA_W-1:0] rd_next;
  logic [`PVPC_DATA_W-1:0] pd_word;
  logic [`PVPC_DATA_W-1:0] cfg_word;

  // Write strobes
  logic                    wr_pd;
  logic                    wr_cfg;
  logic                    wr_dsp;
  logic                    wr_psc;

  // Named control fields and live levels
  logic                    pd_level;
  logic                    force_sd;
  logic                    pre_keep;
  logic                    tx10_save;
  logic                    an_save_off;
  logic                    an_loop;
  logic                    xover_fix;
  logic                    xover_down;
  logic                    pre_short;
  logic                    amp_save;
  logic                    drv_save;
  logic                    cable_open;

  // Next values of derived outputs
  logic [`PVPC_PRE_W-1:0]  pre_next;
  logic                    xover_next;

  // Address decode, one strobe per register
  assign wr_pd  = bus.wr && (bus.addr == `PVPC_ADDR_PD);
  assign wr_cfg = bus.wr && (bus.addr == `PVPC_ADDR_CFG);
  assign wr_dsp = bus.wr && (bus.addr == `PVPC_ADDR_DSP);
  assign wr_psc = bus.wr && (bus.addr == `PVPC_ADDR_PSC);

  // Configuration fields by purpose
  assign pd_level    = cfg_reg[`PVPC_CFG_PD_LEVEL];
  assign force_sd    = cfg_reg[`PVPC_CFG_FORCE_SD];
  assign pre_keep    = cfg_reg[`PVPC_CFG_PRE_CTL];
  assign tx10_save   = cfg_reg[`PVPC_CFG_TX10M_SAVE];
  assign an_save_off = cfg_reg[`PVPC_CFG_AN_SAVE];
  assign an_loop     = cfg_reg[`PVPC_CFG_AN_LOOP];
  assign xover_fix   = cfg_reg[`PVPC_CFG_XOVER_FIX];
  assign xover_down  = cfg_reg[`PVPC_CFG_XOVER_DOWN];

  // Power saving fields
  assign pre_short   = psc_reg[`PVPC_PSC_PRE_SHORT];
  assign amp_save    = psc_reg[`PVPC_PSC_AMPLITUDE];
  assign drv_save    = psc_reg[`PVPC_PSC_TX_DRIVE];

  // Unconnected level, trusted as already debounced by link detection
  assign cable_open  = phy.cable_unplugged;

  // Power-down test bits
  always_ff @(posedge clk) begin
    if (reset) begin
      pd_reg <= PD_BITS'(`PVPC_PD_RESET);
    end else if (wr_pd) begin
      pd_reg <= bus.wdata[PD_BITS-1:0];
    end
  end

  // Configuration word; read-only bits never stored
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_reg <= `PVPC_CFG_RESET;
    end else if (wr_cfg) begin
      // Reserved bit 1 stored as written; software keeps it zero
      cfg_reg <= bus.wdata & `PVPC_CFG_RW_MASK;
    end
  end

  // DSP test word
  always_ff @(posedge clk) begin
    if (reset) begin
      dsp_reg <= `PVPC_DSP_RESET;
    end else if (wr_dsp) begin
      dsp_reg <= bus.wdata;
    end
  end

  // Power saving controls
  always_ff @(posedge clk) begin
    if (reset) begin
      psc_reg <= `PVPC_PSC_RESET;
    end else if (wr_psc) begin
      psc_reg <= bus.wdata & `PVPC_PSC_RW_MASK;
    end
  end

  // Power-down word as read back, upper bits zero
  always_comb begin
    pd_word = '0;
    pd_word[PD_BITS-1:0] = pd_reg;
  end

  // Configuration word as read back, crossover bit live from its flop
  always_comb begin
    cfg_word = cfg_reg;
    cfg_word[`PVPC_CFG_XOVER] = crossover_state;
  end

  // Read mux; unmapped addresses answer zero
  always_comb begin
    rd_next = '0;
    if (bus.rd) begin
      unique case (bus.addr)
        `PVPC_ADDR_PD: begin
          rd_next = pd_word;
        end
        `PVPC_ADDR_CFG: begin
          rd_next = cfg_word;
        end
        `PVPC_ADDR_DSP: begin
          rd_next = dsp_reg;
        end
        `PVPC_ADDR_PSC: begin
          rd_next = psc_reg;
        end
        default: begin
          rd_next = '0;
        end
      endcase
    end
  end

  // Read data stands one cycle only
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data <= '0;
    end else begin
      rd_data <= rd_next;
    end
  end

  // Per-bit power-down drive from the shared level
  for (genvar i = 0; i < PD_BITS; i++) begin : g_pd
    always_ff @(posedge clk) begin
      if (reset) begin
        pd_ctl[i] <= 1'b0;
      end else begin
        // Unselected functions stay powered
        pd_ctl[i] <= pd_reg[i] && pd_level;
      end
    end
  end

  // Signal detect forcing applies at 100 Mbps only
  always_ff @(posedge clk) begin
    if (reset) begin
      signal_detect_ok <= 1'b0;
    end else if (force_sd && phy.speed_100) begin
      signal_detect_ok <= 1'b1;
    end else begin
      signal_detect_ok <= phy.signal_detect;
    end
  end

  // Preamble reduction selection
  always_comb begin
    pre_next = `PVPC_PRE_NONE;
    if (!pre_keep && tx10_save) begin
      if (pre_short) begin
        pre_next = `PVPC_PRE_CUT_SHORT;
      end else begin
        pre_next = `PVPC_PRE_CUT_LONG;
      end
    end
  end

  // Only 10BASE-T preambles are cut; control set keeps them whole
  always_ff @(posedge clk) begin
    if (reset) begin
      preamble_cut_bits <= `PVPC_PRE_NONE;
    end else if (phy.speed_100) begin
      preamble_cut_bits <= `PVPC_PRE_NONE;
    end else begin
      preamble_cut_bits <= pre_next;
    end
  end

  // 10 Mbps transmit power saving
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_10m_power_save <= 1'b0;
    end else begin
      tx_10m_power_save <= tx10_save && !phy.speed_100;
    end
  end

  // Saving during negotiation is on by default (bit low)
  always_ff @(posedge clk) begin
    if (reset) begin
      autoneg_power_save_en <= 1'b0;
    end else begin
      autoneg_power_save_en <= !an_save_off && phy.autoneg_active;
    end
  end

  // Crossover: forced value overrides automatic detection
  always_comb begin
    if (xover_down) begin
      xover_next = xover_fix;
    end else begin
      xover_next = phy.auto_crossover;
    end
  end

  // Reset shows MDI until the first live sample
  always_ff @(posedge clk) begin
    if (reset) begin
      crossover_state <= 1'b0;
    end else begin
      crossover_state <= xover_next;
    end
  end

  // Automatic detection runs unless forced; on from reset
  always_ff @(posedge clk) begin
    if (reset) begin
      auto_crossover_en <= 1'b1;
    end else begin
      auto_crossover_en <= !xover_down;
    end
  end

  // Internal negotiation loopback
  always_ff @(posedge clk) begin
    if (reset) begin
      autoneg_internal_loopback <= 1'b0;
    end else begin
      autoneg_internal_loopback <= an_loop;
    end
  end

  // DSP word straight to the core
  always_ff @(posedge clk) begin
    if (reset) begin
      dsp_test_word <= `PVPC_DSP_RESET;
    end else begin
      dsp_test_word <= dsp_reg;
    end
  end

  // Amplitude cut only while no partner is connected
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_amplitude_reduce <= 1'b0;
    end else begin
      tx_amplitude_reduce <= amp_save && cable_open;
    end
  end

  // Drive current cut only while no partner is connected
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_drive_current_save <= 1'b0;
    end else begin
      tx_drive_current_save <= drv_save && cable_open;
    end
  end

endmodule : pvpc_top

`default_nettype wire

// file: logic/pvpc_regs.svh
`ifndef PVPC_REGS_SVH
`define PVPC_REGS_SVH

// Register indices on the management port
`define PVPC_ADDR_W          5
`define PVPC_DATA_W          16
`define PVPC_ADDR_PD         5'h13
`define PVPC_ADDR_CFG        5'h14
`define PVPC_ADDR_DSP        5'h1B
`define PVPC_ADDR_PSC        5'h1D

// Power-down test register
`define PVPC_PD_BITS         9
`define PVPC_PD_RESET        9'h000

// Configuration register fields
`define PVPC_CFG_RESET       16'h0000
`define PVPC_CFG_RW_MASK     16'hFE7F
`define PVPC_CFG_FORCE_SD    13
`define PVPC_CFG_PRE_CTL     11
`define PVPC_CFG_TX10M_SAVE  10
`define PVPC_CFG_AN_SAVE     9
`define PVPC_CFG_XOVER       7
`define PVPC_CFG_AN_LOOP     6
`define PVPC_CFG_XOVER_FIX   5
`define PVPC_CFG_XOVER_DOWN  4
`define PVPC_CFG_PD_LEVEL    0

// DSP test word
`define PVPC_DSP_RESET       16'h0000

// Power saving register fields
`define PVPC_PSC_RESET       16'h0000
`define PVPC_PSC_RW_MASK     16'h0E00
`define PVPC_PSC_PRE_SHORT   11
`define PVPC_PSC_AMPLITUDE   10
`define PVPC_PSC_TX_DRIVE    9

// Preamble reduction in bits
`define PVPC_PRE_W           5
`define PVPC_PRE_NONE        5'h00
`define PVPC_PRE_CUT_SHORT   5'h0C
`define PVPC_PRE_CUT_LONG    5'h16

`endif

// file: logic/pvpc_pkg.sv
`default_nettype none

package pvpc_pkg;

  // Management port request
  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } pvpc_bus_t;

  // Live state from the PHY core
  typedef struct packed {
    logic speed_100;
    logic signal_detect;
    logic auto_crossover;
    logic cable_unplugged;
    logic autoneg_active;
  } pvpc_phy_t;

endpackage : pvpc_pkg

`default_nettype wire

// file: bench/pvpc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pvpc_chk
  import pvpc_pkg::*;
#(
  parameter int PD_BITS = 9
) (
  input wire logic               clk,
  input wire logic               reset,
  input wire pvpc_bus_t          bus,
  input wire pvpc_phy_t          phy,
  input wire logic [PD_BITS-1:0] pd_ctl,
  input wire logic               signal_detect_ok,
  input wire logic [4:0]         preamble_cut_bits,
  input wire logic               tx_10m_power_save,
  input wire logic               autoneg_power_save_en,
  input wire logic               crossover_state,
  input wire logic               auto_crossover_en,
  input wire logic [15:0]        dsp_test_word,
  input wire logic               tx_amplitude_reduce,
  input wire logic               tx_drive_current_save
);
  logic live_q;
  // Live-input outputs lag reset release by one edge
  always_ff @(posedge clk) begin
    live_q <= !reset;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  pd_hold_a: assert property (live_q && !$past(bus.wr) && !$past(bus.wr, 2) |-> $stable(pd_ctl))
    else $error("power-down outputs moved without a write");
  sd_pass_a: assert property (live_q && !$past(phy.speed_100) |->
    signal_detect_ok == $past(phy.signal_detect)) else $error("signal detect not passed");
  pre_cut_a: assert property (preamble_cut_bits != 5'h00 |-> !$past(phy.speed_100) &&
    preamble_cut_bits inside {5'h0C, 5'h16}) else $error("bad preamble cut");
  tx10_save_a: assert property (tx_10m_power_save |-> !$past(phy.speed_100))
    else $error("10M saving at 100M");
  an_save_a: assert property (autoneg_power_save_en |-> $past(phy.autoneg_active))
    else $error("autoneg saving while idle");
  xover_auto_a: assert property (live_q && auto_crossover_en |->
    crossover_state == $past(phy.auto_crossover)) else $error("crossover not following");
  dsp_word_a: assert property (bus.wr && bus.addr == 5'h1B |-> ##2
    dsp_test_word == $past(bus.wdata, 2)) else $error("dsp word not written");
  amp_cut_a: assert property (tx_amplitude_reduce |-> $past(phy.cable_unplugged))
    else $error("amplitude cut with cable");
  drv_cut_a: assert property (tx_drive_current_save |-> $past(phy.cable_unplugged))
    else $error("drive cut with cable");
  cover property (!auto_crossover_en && crossover_state);
  cover property (preamble_cut_bits == 5'h0C);
  cover property (tx_amplitude_reduce && tx_drive_current_save);
endmodule : pvpc_chk
bind pvpc_top pvpc_chk #(.PD_BITS(PD_BITS)) u_chk (.clk, .reset, .bus, .phy, .pd_ctl,
  .signal_detect_ok, .preamble_cut_bits, .tx_10m_power_save, .autoneg_power_save_en,
  .crossover_state, .auto_crossover_en, .dsp_test_word, .tx_amplitude_reduce,
  .tx_drive_current_save);
`default_nettype wire

// file: bench/pvpc_test.sv
`timescale 1ns/1ps
`default_nettype none
module phy_vendor_power_config_test;
  import pvpc_pkg::*;
  logic        clk;
  logic        reset;
  pvpc_bus_t   b;
  pvpc_phy_t   p;
  logic [15:0] rdd, dsp;
  logic [8:0]  pd;
  logic [4:0]  pre;
  logic        sdok, tx10, an, xs, ace, lp, amp, drv;
  logic [15:0] m [4];
  logic [15:0] d;
  logic [37:0] e;
  logic [15:0] msk [4] = '{16'h01FF, 16'hFE7F, 16'hFFFF, 16'h0E00};
  logic [4:0]  adr [4] = '{5'h13, 5'h14, 5'h1B, 5'h1D};
  int          n_fail, num_checks, seed, i, k;

  pvpc_top u_dut (.clk(clk), .reset(reset), .bus(b), .phy(p), .rd_data(rdd), .pd_ctl(pd),
    .signal_detect_ok(sdok), .preamble_cut_bits(pre), .tx_10m_power_save(tx10),
    .autoneg_power_save_en(an), .crossover_state(xs), .auto_crossover_en(ace),
    .autoneg_internal_loopback(lp), .dsp_test_word(dsp), .tx_amplitude_reduce(amp),
    .tx_drive_current_save(drv));

  // 50 ns period
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end

  task automatic summarize();
    if (n_fail == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One-cycle strobes; a free edge after each keeps drivers single per step
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge clk) begin b.wr <= 1'b1; b.addr <= a; b.wdata <= v; end
    @(posedge clk) b.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [15:0] v);
    @(posedge clk) begin b.rd <= 1'b1; b.addr <= a; end
    @(posedge clk) b.rd <= 1'b0;
    #1 chk(rdd, v);
  endtask : rd

  // Expected port levels from register image and live inputs
  function automatic logic [37:0] model();
    logic [15:0] c;
    logic [4:0]  cut;
    c = m[1];
    cut = (!p.speed_100 && !c[11] && c[10]) ? (m[3][11] ? 5'h0C : 5'h16) : 5'h00;
    return {m[0][8:0] & {9{c[0]}}, (c[13] & p.speed_100) | p.signal_detect, cut,
      c[10] & !p.speed_100, !c[9] & p.autoneg_active,
      c[4] ? c[5] : p.auto_crossover, !c[4], c[6], m[2],
      m[3][10] & p.cable_unplugged, m[3][9] & p.cable_unplugged};
  endfunction : model

  // Hang guard
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    summarize();
  end

  initial begin
    seed = 15903;
    b = '0;
    p = '0;
    reset = 1'b1;
    m = '{default: 16'h0000};
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    // Pass 0 sees reset values, later passes random traffic
    for (i = 0; i < 40; i++) begin
      if (i > 0) begin
        @(posedge clk) p <= 5'($random(seed));
        for (k = 0; k < 4; k++) begin
          d = 16'($random(seed));
          if (k == 1) d[1] = 1'b0;
          wr(adr[k], d);
          m[k] = d & msk[k];
        end
        wr(5'h15, 16'($random(seed)));
      end
      repeat (3) @(posedge clk);
      #1 e = model();
      chk({pd, sdok, pre, tx10, an, xs, ace, lp, dsp, amp, drv}, e);
      for (k = 0; k < 4; k++) begin
        rd(adr[k], (k == 1) ? (m[1] | {8'h00, e[20], 7'h00}) : m[k]);
      end
      rd(5'h15, 16'h0000);
    end
    summarize();
  end
endmodule : phy_vendor_power_config_test
`default_nettype wire
